// *** hw/prd_pkg.sv ***
// package of constants and types for the pll ratio strap decoder
package prd_pkg;
    // ------------------------------------------------------------
    // strap and field widths
    // ------------------------------------------------------------
    localparam int PRD_CODE_W = 5;
    localparam int PRD_MULT_W = 4; // multipliers in half steps (x2)
    localparam int PRD_HOLD_W = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [4:0] PRD_RST_CODE = 5'h1F;
    localparam logic [4:0] PRD_RST_READBACK = 5'h1F;
    localparam logic [3:0] PRD_RST_MULT = 4'h0;
    localparam logic PRD_RST_CFG_BIT = 1'h1;
    localparam logic PRD_RST_OPEN_DRAIN = 1'h0;
    localparam logic [3:0] PRD_RST_HOLD = 4'h0;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam int PRD_RELEASE_CYC = 1; // drive high for one clock

    // ------------------------------------------------------------
    // sustained three-state pin states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PRD_ST_IDLE = 2'b00,
        PRD_ST_DRIVE = 2'b01,
        PRD_ST_PARK = 2'b10
    } prd_sts_t;

    // ------------------------------------------------------------
    // decoded entry of the strap table
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] pci_mem_x2;
        logic [3:0] mem_cpu_x2;
        logic bypass;
        logic clk_off;
        logic reserved;
        logic [4:0] readback;
    } prd_entry_t;
endpackage

// *** hw/prd_strap_table.sv ***
// combinational lookup from strap code to clock settings
`timescale 1ns/1ps
module prd_strap_table
    import prd_pkg::*;
(
    input wire logic [4:0] code_i,
    output prd_entry_t entry_o
);
    // ------------------------------------------------------------
    // table entry builder
    // ------------------------------------------------------------
    function automatic prd_entry_t mk(input logic [3:0] pm, input logic [3:0] mc,
                                      input logic byp, input logic off,
                                      input logic rsv, input logic [4:0] rb);
        prd_entry_t e;
        e.pci_mem_x2 = pm;
        e.mem_cpu_x2 = mc;
        e.bypass = byp;
        e.clk_off = off;
        e.reserved = rsv;
        e.readback = rb;
        return e;
    endfunction

    // ------------------------------------------------------------
    // lookup, bypass forces pci to mem 1:1
    // ------------------------------------------------------------
    always_comb begin
        case (code_i)
            5'h00: entry_o = mk(4'h6, 4'h5, 1'h0, 1'h0, 1'h0, 5'h06);
            5'h01: entry_o = mk(4'h6, 4'h6, 1'h0, 1'h0, 1'h0, 5'h18);
            5'h02: entry_o = mk(4'h2, 4'h4, 1'h0, 1'h0, 1'h0, 5'h05);
            5'h03: entry_o = mk(4'h2, 4'h4, 1'h1, 1'h0, 1'h0, 5'h05);
            5'h04: entry_o = mk(4'h4, 4'h4, 1'h0, 1'h0, 1'h0, 5'h05);
            5'h05: entry_o = mk(4'h2, 4'h5, 1'h1, 1'h0, 1'h0, 5'h06);
            5'h07: entry_o = mk(4'h2, 4'h6, 1'h1, 1'h0, 1'h0, 5'h18);
            5'h08: entry_o = mk(4'h2, 4'h6, 1'h0, 1'h0, 1'h0, 5'h18);
            5'h0A: entry_o = mk(4'h4, 4'h9, 1'h0, 1'h0, 1'h0, 5'h07);
            5'h0C: entry_o = mk(4'h4, 4'h5, 1'h0, 1'h0, 1'h0, 5'h06);
            5'h0E: entry_o = mk(4'h4, 4'h6, 1'h0, 1'h0, 1'h0, 5'h18);
            5'h10: entry_o = mk(4'h6, 4'h4, 1'h0, 1'h0, 1'h0, 5'h04);
            5'h12: entry_o = mk(4'h3, 4'h4, 1'h0, 1'h0, 1'h0, 5'h04);
            5'h14: entry_o = mk(4'h4, 4'h7, 1'h0, 1'h0, 1'h0, 5'h1E);
            5'h16: entry_o = mk(4'h4, 4'h8, 1'h0, 1'h0, 1'h0, 5'h1A);
            5'h18: entry_o = mk(4'h5, 4'h6, 1'h0, 1'h0, 1'h0, 5'h18);
            5'h1A: entry_o = mk(4'h2, 4'h8, 1'h0, 1'h0, 1'h0, 5'h1A);
            5'h1C: entry_o = mk(4'h3, 4'h6, 1'h0, 1'h0, 1'h0, 5'h18);
            5'h1D: entry_o = mk(4'h3, 4'h5, 1'h0, 1'h0, 1'h0, 5'h06);
            5'h1E: entry_o = mk(4'h0, 4'h0, 1'h0, 1'h1, 1'h0, 5'h0F);
            5'h1F: entry_o = mk(4'h0, 4'h0, 1'h0, 1'h1, 1'h0, 5'h1F);
            // unlisted codes: unsupported, treated like clock off
            default: entry_o = mk(4'h0, 4'h0, 1'h0, 1'h1, 1'h1, 5'h1F);
        endcase
    end
endmodule

// *** hw/prd_top.sv ***
// reset-time strap capture and clock ratio decode top level
`timescale 1ns/1ps
// Overview of operation
// - the five-bit ratio strap is captured at reset and sets up clock generation.
// - one code picks both the pci-to-memory and the memory-to-cpu multiplier.
// - every reset configuration pin has a pull-up only during reset, so open reads one.
// - low data lane bit 0 is a configuration input pulled up only in reset.
// - bus grant line four is sampled in reset, pulled up only in reset, defaults one.
// - selected outputs are driven or open drain by a setting, driven after reset.
// - pci output hold delay follows a programmable hold adjust value.
// - sustained three-state pins drive high one clock before releasing.
// - bypass codes clock the cpu from the pci input, peripheral pll off, 1:1.
// - clock-off codes keep every internal clock still.
// - the cpu readback holds a per-code cpu pll code; codes 02h and 10h share a memory-to-cpu multiplier but read 05h and 04h.
module prd_top
    import prd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [4:0] ratio_strap_i,
    input wire logic low_data_lane_bit0_i,
    input wire logic bus_grant_line_four_i,
    input wire logic power_mgmt_control_two_od_i,
    input wire logic [3:0] output_hold_adjust_i,
    input wire logic sts_drive_i,
    input wire logic sts_level_i,
    input wire logic od_pin_level_i,
    output logic strap_pullup_en_o,
    output logic [4:0] latched_code_o,
    output logic [3:0] pci_mem_mult_x2_o,
    output logic [3:0] mem_cpu_mult_x2_o,
    output logic pll_bypass_o,
    output logic periph_pll_en_o,
    output logic clocks_off_o,
    output logic code_unsupported_o,
    output logic [4:0] cpu_ratio_readback_o,
    output logic low_data_lane_cfg_o,
    output logic bus_grant_cfg_o,
    output logic od_pin_out_o,
    output logic od_pin_oe_o,
    output logic [3:0] hold_delay_sel_o,
    output logic sts_pin_out_o,
    output logic sts_pin_oe_o
);
    // ------------------------------------------------------------
    // pin synchronisers, three stages each
    // ------------------------------------------------------------
    logic [6:0] sync1_ff, sync2_ff, sync3_ff;
    logic [6:0] nxt_sync1, nxt_sync2, nxt_sync3;
    logic [6:0] stable_ff, nxt_stable;
    // pins in order: strap, data lane bit 0, grant four
    always_comb begin
        nxt_sync1 = {ratio_strap_i, low_data_lane_bit0_i, bus_grant_line_four_i};
        nxt_sync2 = sync1_ff;
        nxt_sync3 = sync2_ff;
        nxt_stable = stable_ff;
        for (int i = 0; i < 7; i++) begin
            if (sync2_ff[i] == sync3_ff[i]) begin
                nxt_stable[i] = sync3_ff[i];
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync1_ff <= 7'h7F;
            sync2_ff <= 7'h7F;
            sync3_ff <= 7'h7F;
            stable_ff <= 7'h7F;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            sync3_ff <= nxt_sync3;
            stable_ff <= nxt_stable;
        end
    end

    // pull-ups on only while reset is held
    assign strap_pullup_en_o = rst_i;

    // ------------------------------------------------------------
    // capture of configuration at reset release
    // ------------------------------------------------------------
    logic armed_ff, nxt_armed;
    logic [4:0] code_ff, nxt_code;
    logic dl0_ff, nxt_dl0;
    logic bus_grant_line_four_ff, nxt_bus_grant_line_four;
    logic [1:0] settle_ff, nxt_settle;
    // sample the value the agreement stage loads at the fourth edge after release,
    // stable_ff itself still holds the preset ones at that edge
    always_comb begin
        nxt_armed = armed_ff;
        nxt_code = code_ff;
        nxt_dl0 = dl0_ff;
        nxt_bus_grant_line_four = bus_grant_line_four_ff;
        nxt_settle = settle_ff;
        if (armed_ff) begin
            if (settle_ff == 2'h3) begin
                nxt_code = nxt_stable[6:2];
                nxt_dl0 = nxt_stable[1];
                nxt_bus_grant_line_four = nxt_stable[0];
                nxt_armed = 1'h0;
            end else begin
                nxt_settle = settle_ff + 2'h1;
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            armed_ff <= 1'h1;
            code_ff <= PRD_RST_CODE;
            dl0_ff <= PRD_RST_CFG_BIT;
            bus_grant_line_four_ff <= PRD_RST_CFG_BIT;
            settle_ff <= 2'h0;
        end else begin
            armed_ff <= nxt_armed;
            code_ff <= nxt_code;
            dl0_ff <= nxt_dl0;
            bus_grant_line_four_ff <= nxt_bus_grant_line_four;
            settle_ff <= nxt_settle;
        end
    end

    // ------------------------------------------------------------
    // decode and registered ratio outputs
    // ------------------------------------------------------------
    prd_entry_t entry;
    prd_strap_table u_table (
        .code_i(code_ff),
        .entry_o(entry)
    );
    logic [3:0] pm_ff, mc_ff, nxt_pm, nxt_mc;
    logic byp_ff, off_ff, rsv_ff, nxt_byp, nxt_off, nxt_rsv;
    logic [4:0] rb_ff, nxt_rb;
    always_comb begin
        nxt_pm = entry.bypass ? 4'h2 : entry.pci_mem_x2;
        nxt_mc = entry.mem_cpu_x2;
        nxt_byp = entry.bypass;
        nxt_off = entry.clk_off;
        nxt_rsv = entry.reserved;
        nxt_rb = entry.readback;
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pm_ff <= PRD_RST_MULT;
            mc_ff <= PRD_RST_MULT;
            byp_ff <= 1'h0;
            off_ff <= 1'h1;
            rsv_ff <= 1'h0;
            rb_ff <= PRD_RST_READBACK;
        end else begin
            pm_ff <= nxt_pm;
            mc_ff <= nxt_mc;
            byp_ff <= nxt_byp;
            off_ff <= nxt_off;
            rsv_ff <= nxt_rsv;
            rb_ff <= nxt_rb;
        end
    end
    assign latched_code_o = code_ff;
    assign pci_mem_mult_x2_o = pm_ff;
    assign mem_cpu_mult_x2_o = mc_ff;
    assign pll_bypass_o = byp_ff;
    assign periph_pll_en_o = ~byp_ff & ~off_ff;
    assign clocks_off_o = off_ff;
    assign code_unsupported_o = rsv_ff;
    assign cpu_ratio_readback_o = rb_ff;
    assign low_data_lane_cfg_o = dl0_ff;
    assign bus_grant_cfg_o = bus_grant_line_four_ff;

    // ------------------------------------------------------------
    // driven or open-drain output and hold delay select
    // ------------------------------------------------------------
    logic od_mode_ff, nxt_od_mode;
    logic [3:0] hold_ff, nxt_hold;
    always_comb begin
        nxt_od_mode = power_mgmt_control_two_od_i;
        nxt_hold = output_hold_adjust_i;
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            od_mode_ff <= PRD_RST_OPEN_DRAIN;
            hold_ff <= PRD_RST_HOLD;
        end else begin
            od_mode_ff <= nxt_od_mode;
            hold_ff <= nxt_hold;
        end
    end
    // open drain drives only lows
    assign od_pin_out_o = od_mode_ff ? 1'h0 : od_pin_level_i;
    assign od_pin_oe_o = od_mode_ff ? ~od_pin_level_i : 1'h1;
    assign hold_delay_sel_o = hold_ff;

    // ------------------------------------------------------------
    // sustained three-state pin
    // ------------------------------------------------------------
    prd_sts_t sts_ff, nxt_sts;
    logic sts_out_ff, nxt_sts_out, sts_oe_ff, nxt_sts_oe;
    always_comb begin
        nxt_sts = sts_ff;
        nxt_sts_out = sts_out_ff;
        nxt_sts_oe = sts_oe_ff;
        case (sts_ff)
            PRD_ST_IDLE: begin
                nxt_sts_oe = 1'h0;
                if (sts_drive_i) begin
                    nxt_sts = PRD_ST_DRIVE;
                    nxt_sts_out = sts_level_i;
                    nxt_sts_oe = 1'h1;
                end
            end
            PRD_ST_DRIVE: begin
                nxt_sts_out = sts_level_i;
                if (!sts_drive_i) begin
                    nxt_sts = PRD_ST_PARK;
                    nxt_sts_out = 1'h1;
                end
            end
            PRD_ST_PARK: begin
                nxt_sts = PRD_ST_IDLE;
                nxt_sts_oe = 1'h0;
            end
            default: begin
                nxt_sts = PRD_ST_IDLE;
                nxt_sts_oe = 1'h0;
            end
        endcase
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sts_ff <= PRD_ST_IDLE;
            sts_out_ff <= 1'h0;
            sts_oe_ff <= 1'h0;
        end else begin
            sts_ff <= nxt_sts;
            sts_out_ff <= nxt_sts_out;
            sts_oe_ff <= nxt_sts_oe;
        end
    end
    assign sts_pin_out_o = sts_out_ff;
    assign sts_pin_oe_o = sts_oe_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    pullup_reset_a: assert property (@(posedge core_clk_i) strap_pullup_en_o == rst_i)
        else $error("pullup enable not tied to reset");
    bypass_ratio_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        byp_ff |-> (pm_ff == 4'h2 && !periph_pll_en_o))
        else $error("bypass not 1:1 or pll on");
    off_pll_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        off_ff |-> !periph_pll_en_o)
        else $error("pll enabled in clock off");
    code_capture_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (armed_ff && settle_ff == 2'h3) |=> code_ff == stable_ff[6:2])
        else $error("strap not captured");
    cfg_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !armed_ff |=> $stable(code_ff) && $stable(dl0_ff) && $stable(bus_grant_line_four_ff))
        else $error("configuration changed after capture");
    ratio_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !armed_ff |-> ##2 (mc_ff == $past(entry.mem_cpu_x2, 2)))
        else $error("cpu multiplier mismatch");
    readback_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !armed_ff |-> ##1 rb_ff == $past(entry.readback))
        else $error("readback mismatch");
    driven_default_a: assert property (@(posedge core_clk_i)
        $fell(rst_i) |-> od_pin_oe_o)
        else $error("output not driven after reset");
    hold_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ##1 hold_delay_sel_o == $past(output_hold_adjust_i))
        else $error("hold delay not following");
    sts_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (sts_ff == PRD_ST_PARK) |-> (sts_pin_out_o && sts_pin_oe_o) ##1 !sts_pin_oe_o)
        else $error("three-state release order wrong");
    grant_default_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (armed_ff && settle_ff == 2'h3) |=> bus_grant_line_four_ff == stable_ff[0])
        else $error("grant four not captured");
    reserved_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rsv_ff |-> off_ff)
        else $error("reserved code not held off");
    bypass_cov: cover property (@(posedge core_clk_i) !armed_ff && byp_ff);
    off_cov: cover property (@(posedge core_clk_i) !armed_ff && off_ff && !rsv_ff);
    reserved_cov: cover property (@(posedge core_clk_i) rsv_ff);
    sts_cov: cover property (@(posedge core_clk_i) sts_ff == PRD_ST_PARK);
endmodule

// *** tb/prd_board_model.sv ***
// board side model: strap drivers and the resolved level of each configuration pin
`timescale 1ns/1ps
module prd_board_model (
    input wire logic core_clk_i,
    input wire logic pullup_en_i,
    input wire logic drv_en_i,
    input wire logic [4:0] drv_code_i,
    input wire logic [1:0] drv_cfg_en_i,
    input wire logic [1:0] drv_cfg_i,
    output logic [4:0] code_pin_o,
    output logic [1:0] cfg_pin_o
);
    logic [4:0] last_code_ff;
    logic [1:0] last_cfg_ff;

    // released pins go to the pull-up level, else flip from their last level
    // reserved codes reach the capture only when a scenario drives them, released pins flip and are captured as 1F
    always_comb begin
        code_pin_o = drv_en_i ? drv_code_i : (pullup_en_i ? 5'h1F : ~last_code_ff);
        cfg_pin_o = (drv_cfg_en_i & drv_cfg_i) |
                    (~drv_cfg_en_i & (pullup_en_i ? 2'h3 : ~last_cfg_ff));
    end

    // last level seen on each pin
    always_ff @(posedge core_clk_i) begin
        last_code_ff <= code_pin_o;
        last_cfg_ff <= cfg_pin_o;
    end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the strap decoder top level
`timescale 1ns/1ps
module testbench;
    import prd_pkg::*;
    logic clk, rst, od_mode, od_lvl, sts_drive, sts_lvl, drv_en;
    logic [3:0] hold_i;
    logic [4:0] drv_code, code_pin;
    logic [1:0] drv_cfg_en, drv_cfg, cfg_pin;
    logic pullup_en, byp, pll_en, off, uns, ldl, bgc, od_out, od_oe, sts_out, sts_oe;
    logic [4:0] latched, readback;
    logic [3:0] pm, mc, hold_o;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed;

    prd_board_model u_prd_board_model (.core_clk_i(clk), .pullup_en_i(pullup_en),
        .drv_en_i(drv_en), .drv_code_i(drv_code), .drv_cfg_en_i(drv_cfg_en),
        .drv_cfg_i(drv_cfg), .code_pin_o(code_pin), .cfg_pin_o(cfg_pin));

    prd_top u_prd_top (.core_clk_i(clk), .rst_i(rst), .ratio_strap_i(code_pin),
        .low_data_lane_bit0_i(cfg_pin[0]), .bus_grant_line_four_i(cfg_pin[1]),
        .power_mgmt_control_two_od_i(od_mode), .output_hold_adjust_i(hold_i),
        .sts_drive_i(sts_drive), .sts_level_i(sts_lvl), .od_pin_level_i(od_lvl),
        .strap_pullup_en_o(pullup_en), .latched_code_o(latched), .pci_mem_mult_x2_o(pm),
        .mem_cpu_mult_x2_o(mc), .pll_bypass_o(byp), .periph_pll_en_o(pll_en),
        .clocks_off_o(off), .code_unsupported_o(uns), .cpu_ratio_readback_o(readback),
        .low_data_lane_cfg_o(ldl), .bus_grant_cfg_o(bgc), .od_pin_out_o(od_out),
        .od_pin_oe_o(od_oe), .hold_delay_sel_o(hold_o), .sts_pin_out_o(sts_out),
        .sts_pin_oe_o(sts_oe));

    // clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // expected entry: {readback, pci-mem x2, mem-cpu x2, bypass, off, unsupported}
    function automatic logic [15:0] exp_entry(input logic [4:0] c);
        case (c)
            5'h00: return {5'h06, 4'h6, 4'h5, 3'h0};
            5'h01: return {5'h18, 4'h6, 4'h6, 3'h0};
            5'h02: return {5'h05, 4'h2, 4'h4, 3'h0};
            5'h03: return {5'h05, 4'h2, 4'h4, 3'h4};
            5'h04: return {5'h05, 4'h4, 4'h4, 3'h0};
            5'h05: return {5'h06, 4'h2, 4'h5, 3'h4};
            5'h07: return {5'h18, 4'h2, 4'h6, 3'h4};
            5'h08: return {5'h18, 4'h2, 4'h6, 3'h0};
            5'h0A: return {5'h07, 4'h4, 4'h9, 3'h0};
            5'h0C: return {5'h06, 4'h4, 4'h5, 3'h0};
            5'h0E: return {5'h18, 4'h4, 4'h6, 3'h0};
            5'h10: return {5'h04, 4'h6, 4'h4, 3'h0};
            5'h12: return {5'h04, 4'h3, 4'h4, 3'h0};
            5'h14: return {5'h1E, 4'h4, 4'h7, 3'h0};
            5'h16: return {5'h1A, 4'h4, 4'h8, 3'h0};
            5'h18: return {5'h18, 4'h5, 4'h6, 3'h0};
            5'h1A: return {5'h1A, 4'h2, 4'h8, 3'h0};
            5'h1C: return {5'h18, 4'h3, 4'h6, 3'h0};
            5'h1D: return {5'h06, 4'h3, 4'h5, 3'h0};
            5'h1E: return {5'h0F, 8'h00, 3'h2};
            5'h1F: return {5'h1F, 8'h00, 3'h2};
            default: return {5'h1F, 8'h00, 3'h3};
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // reset with given pin drive, release pins after capture, then compare
    task automatic strap_run(input logic den, input logic [4:0] c, input logic [1:0] cv);
        logic [15:0] e;
        e = exp_entry(den ? c : 5'h1F);
        @(posedge clk) #1;
        rst = 1'b1;
        drv_en = den;
        drv_code = c;
        drv_cfg_en = {den, den};
        drv_cfg = cv;
        repeat (2) @(posedge clk);
        #1;
        check(pullup_en, 1'b1);
        rst = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(pullup_en, 1'b0);
        drv_en = 1'b0;
        drv_cfg_en = 2'h0;
        repeat (4) @(posedge clk);
        #1;
        check(latched, den ? c : 5'h1F);
        check(readback, e[15:11]);
        check({byp, off, uns}, e[2:0]);
        check(pll_en, !(e[2] || e[1]));
        if (!e[1]) check({pm, mc}, e[10:3]);
        check({bgc, ldl}, den ? cv : 2'h3);
    endtask

    task automatic sts_run(input int n);
        @(posedge clk) #1;
        check(sts_oe, 1'b0);
        sts_drive = 1'b1;
        sts_lvl = 1'($urandom);
        for (int k = 0; k < n; k++) begin
            @(posedge clk) #1;
            check({sts_out, sts_oe}, {sts_lvl, 1'b1});
            sts_lvl = 1'($urandom);
        end
        sts_drive = 1'b0;
        @(posedge clk) #1;
        check({sts_out, sts_oe}, 2'h3);
        @(posedge clk) #1;
        check(sts_oe, 1'b0);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        drv_en = 1'b0;
        drv_code = 5'h00;
        drv_cfg_en = 2'h0;
        drv_cfg = 2'h0;
        od_mode = 1'b0;
        od_lvl = 1'b0;
        hold_i = 4'h0;
        sts_drive = 1'b0;
        sts_lvl = 1'b0;
        seed = $urandom(29);
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 32; i++) strap_run(1'b1, 5'(i), 2'($urandom));
        strap_run(1'b1, 5'h0A, 2'h0);
        strap_run(1'b0, 5'h00, 2'h0);
        $display("strap table test done");
        // driven in reset, then open drain and driven modes
        @(posedge clk) #1;
        rst = 1'b1;
        od_mode = 1'b1;
        od_lvl = 1'($urandom);
        repeat (2) @(posedge clk);
        #1 check({od_out, od_oe}, {od_lvl, 1'b1});
        rst = 1'b0;
        for (int m = 1; m >= 0; m--) begin
            @(posedge clk) #1 od_mode = 1'(m);
            repeat (2) @(posedge clk);
            for (int l = 0; l < 2; l++) begin
                #1 od_lvl = 1'(l);
                #1 check({od_out, od_oe}, m ? {1'b0, ~od_lvl} : {od_lvl, 1'b1});
                @(posedge clk);
            end
        end
        $display("open drain test done");
        for (int h = 0; h < 6; h++) begin
            @(posedge clk) #1 hold_i = (h == 0) ? 4'hF : 4'($urandom);
            repeat (2) @(posedge clk);
            #1 check(hold_o, hold_i);
        end
        $display("hold delay test done");
        sts_run(1);
        sts_run(5);
        $display("three-state test done");
        summarize();
    end
endmodule
